// file: design/fps_pkg.sv
// Functional notes
// - Frame interval counter makes evenly spaced frames
// - Continuous frame series schedules all sampling
// - Sample frame: frame start raises analog trigger
// - Non-sample frame: frame start raises digital trigger
// - Sample frame: analog end raises digital trigger
// - Started indications wait for oscillator switch
// - Started means phase begun and clock fast
// - Distinguish sample frames from non-sample frames
// - Any interleave of sample and non-sample frames
// - Debug leaves gating register behaviour unchanged
// - Sleep turns oscillator off, lowest power
// - Fast-clock stop keeps oscillator fast, analog phase
// - Slow-clock stop runs oscillator slow, idle phase
// - Sample frame start with analog enable: slow to fast stop
// - Debug keeps oscillator on at fast frequency
`default_nettype none
package fps_pkg;
   // Frame interval in reference clock cycles
   localparam int unsigned FRAME_LEN = 1000;
   localparam logic [15:0] FRAME_LAST = 16'(FRAME_LEN - 1);
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   // Oscillator switch latency in cycles
   localparam logic [3:0] OSC_SWITCH_CYC = 4'h8;
   localparam logic [3:0] WAIT_ZERO = 4'h0;
   localparam logic [3:0] WAIT_ONE = 4'h1;
   // Register indices
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STOP = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_FRAME = 4'h3;
   // Control register bit positions
   localparam int CTRL_COUNT_EN = 0;
   localparam int CTRL_SAMPLE_NEXT = 1;
   localparam int CTRL_DEBUG = 2;
   // Stop control register bit positions
   localparam int STOP_SLOW_SEL = 0;
   localparam int STOP_FAST_SEL = 1;
   localparam int STOP_NONE_SEL = 2;
   localparam int STOP_ANALOG_EN = 3;

   typedef enum {
      FPS_RESET,
      FPS_RUN,
      FPS_FAST_STOP,
      FPS_SLOW_STOP,
      FPS_NO_CLOCK
   } fps_mode_t;

   // Clock plan driven to the clock tree
   typedef struct packed {
      logic osc_on;
      logic osc_fast;
      logic cpu_clk_en;
      logic afe_clk_en;
   } fps_clk_t;

   // Phase trigger group
   typedef struct packed {
      logic start_analog;
      logic start_digital;
      logic analog_started;
      logic digital_started;
      logic frame_start;
   } fps_trig_t;
endpackage
`default_nettype wire

// file: design/fps_frame_counter.sv
`default_nettype none
// Frame interval counter: emits one pulse per frame interval
module fps_frame_counter (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic enable_i,
   output logic frame_pulse_o,
   output logic [15:0] count_o
);
   typedef struct packed {
      logic [15:0] cnt;
      logic pulse;
   } fps_fc_state_t;

   fps_fc_state_t st_reg;
   fps_fc_state_t st_next;

   // Free count wraps at the frame length, giving evenly spaced pulses
   always_comb
   begin
      st_next = st_reg;
      st_next.pulse = 1'b0;
      if (enable_i)
      begin
         if (st_reg.cnt == fps_pkg::FRAME_LAST)
         begin
            st_next.cnt = fps_pkg::CNT_ZERO;
            st_next.pulse = 1'b1;
         end
         else
         begin
            st_next.cnt = st_reg.cnt + fps_pkg::CNT_ONE;
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign frame_pulse_o = st_reg.pulse;
   assign count_o = st_reg.cnt;
endmodule
`default_nettype wire

// file: design/fps_frame_phase_sequencer.sv
`default_nettype none
// Frame phase sequencer: frame triggers, phase confirmations and clock plan
module fps_frame_phase_sequencer (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // CPU events
   input wire logic stop_instr_i,
   input wire logic wake_irq_i,
   // Analog front end end-of-phase, asynchronous
   input wire logic analog_done_i,
   // Trigger outputs
   output logic start_analog_o,
   output logic start_digital_o,
   output logic analog_started_o,
   output logic digital_started_o,
   // Clock plan
   output logic osc_on_o,
   output logic osc_fast_o,
   output logic cpu_clk_en_o,
   output logic afe_clk_en_o
);
   // Whole module state
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] stop;
      logic [7:0] rdata;
      fps_pkg::fps_mode_t mode;
      fps_pkg::fps_trig_t trig;
      fps_pkg::fps_clk_t clk;
      logic sample_frame;
      logic pend_analog;
      logic pend_digital;
      logic [3:0] osc_wait;
      logic [2:0] sync;
      logic done_seen;
   } fps_state_t;

   fps_state_t st_reg;
   fps_state_t st_next;
   logic frame_pulse;
   logic [15:0] frame_count;

   // Frame timebase; gated by the count enable bit
   fps_frame_counter u_frame (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .enable_i(st_reg.ctrl[fps_pkg::CTRL_COUNT_EN]),
      .frame_pulse_o(frame_pulse),
      .count_o(frame_count)
   );

   // Clock plan for a mode; debug keeps every clock fast
   function automatic fps_pkg::fps_clk_t clk_plan(input fps_pkg::fps_mode_t m,
                                                  input logic dbg);
      fps_pkg::fps_clk_t c;
      c = '{osc_on: 1'b1, osc_fast: 1'b1, cpu_clk_en: 1'b1, afe_clk_en: 1'b1};
      if (dbg)
      begin
         c = c;
      end
      else
      begin
         case (m)
            fps_pkg::FPS_FAST_STOP:
            begin
               c.cpu_clk_en = 1'b0;
            end
            fps_pkg::FPS_SLOW_STOP:
            begin
               c.osc_fast = 1'b0;
               c.cpu_clk_en = 1'b0;
               c.afe_clk_en = 1'b0;
            end
            fps_pkg::FPS_NO_CLOCK:
            begin
               c = '0;
            end
            default:
            begin
               c = c;
            end
         endcase
      end
      return c;
   endfunction

   // Next state
   always_comb
   begin
      logic done_sync;
      logic done_rise;
      logic dbg;
      fps_pkg::fps_clk_t plan;
      done_sync = 1'b0;
      done_rise = 1'b0;
      dbg = 1'b0;
      plan = '0;
      st_next = st_reg;
      st_next.trig = '0;
      st_next.rdata = 8'h00;
      dbg = st_reg.ctrl[fps_pkg::CTRL_DEBUG];
      // Three-stage synchroniser; change counted when stages two and three agree
      st_next.sync = {st_reg.sync[1:0], analog_done_i};
      done_sync = st_reg.sync[1] & st_reg.sync[2];
      done_rise = done_sync & ~st_reg.done_seen;
      if (st_reg.sync[1] == st_reg.sync[2])
      begin
         st_next.done_seen = st_reg.sync[2];
      end
      // Register writes
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            fps_pkg::ADDR_CTRL:
            begin
               st_next.ctrl = reg_wdata_i;
            end
            fps_pkg::ADDR_STOP:
            begin
               st_next.stop = reg_wdata_i;
            end
            default:
            begin
               st_next.ctrl = st_next.ctrl;
            end
         endcase
      end
      // Register reads, data valid next cycle
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            fps_pkg::ADDR_CTRL: st_next.rdata = st_reg.ctrl;
            fps_pkg::ADDR_STOP: st_next.rdata = st_reg.stop;
            fps_pkg::ADDR_STATUS:
               st_next.rdata = {1'b0, st_reg.sample_frame, st_reg.pend_analog,
                                st_reg.pend_digital, 1'b0, 3'(st_reg.mode)};
            fps_pkg::ADDR_FRAME: st_next.rdata = frame_count[7:0];
            default: st_next.rdata = 8'h00;
         endcase
      end
      // Mode machine
      case (st_reg.mode)
         fps_pkg::FPS_RESET:
         begin
            st_next.mode = fps_pkg::FPS_RUN;
         end
         fps_pkg::FPS_RUN:
         begin
            if (stop_instr_i)
            begin
               // Debug emulates every stop as fast-clock stop
               if (dbg || st_reg.stop[fps_pkg::STOP_FAST_SEL])
                  st_next.mode = fps_pkg::FPS_FAST_STOP;
               else if (st_reg.stop[fps_pkg::STOP_SLOW_SEL])
                  st_next.mode = fps_pkg::FPS_SLOW_STOP;
               else if (st_reg.stop[fps_pkg::STOP_NONE_SEL])
                  st_next.mode = fps_pkg::FPS_NO_CLOCK;
            end
         end
         fps_pkg::FPS_SLOW_STOP:
         begin
            if (frame_pulse && st_reg.stop[fps_pkg::STOP_ANALOG_EN]
                && st_reg.ctrl[fps_pkg::CTRL_SAMPLE_NEXT])
               st_next.mode = fps_pkg::FPS_FAST_STOP;
            else if (frame_pulse || wake_irq_i)
               st_next.mode = fps_pkg::FPS_RUN;
         end
         fps_pkg::FPS_FAST_STOP:
         begin
            if (done_rise || wake_irq_i)
               st_next.mode = fps_pkg::FPS_RUN;
         end
         fps_pkg::FPS_NO_CLOCK:
         begin
            if (wake_irq_i)
               st_next.mode = fps_pkg::FPS_RUN;
         end
         default:
         begin
            st_next.mode = fps_pkg::FPS_RESET;
         end
      endcase
      // Frame start decides the frame kind and its trigger
      if (frame_pulse)
      begin
         st_next.trig.frame_start = 1'b1;
         st_next.sample_frame = st_reg.ctrl[fps_pkg::CTRL_SAMPLE_NEXT];
         if (st_reg.ctrl[fps_pkg::CTRL_SAMPLE_NEXT])
         begin
            st_next.trig.start_analog = 1'b1;
            st_next.pend_analog = 1'b1;
         end
         else
         begin
            st_next.trig.start_digital = 1'b1;
            st_next.pend_digital = 1'b1;
         end
      end
      // End of analog phase starts the digital phase of a sample frame
      if (done_rise && st_reg.sample_frame)
      begin
         st_next.trig.start_digital = 1'b1;
         st_next.pend_digital = 1'b1;
         st_next.sample_frame = 1'b0;
      end
      // Oscillator switch: count down while moving from slow or off to fast
      plan = clk_plan(st_next.mode, dbg);
      if (plan.osc_fast && !(st_reg.clk.osc_fast && st_reg.clk.osc_on))
         st_next.osc_wait = fps_pkg::OSC_SWITCH_CYC;
      else if (st_reg.osc_wait != fps_pkg::WAIT_ZERO)
         st_next.osc_wait = st_reg.osc_wait - fps_pkg::WAIT_ONE;
      st_next.clk = plan;
      // Confirmations only once the oscillator really runs fast
      if (st_reg.clk.osc_fast && st_reg.clk.osc_on && st_reg.osc_wait == fps_pkg::WAIT_ZERO)
      begin
         if (st_reg.pend_analog)
         begin
            st_next.trig.analog_started = 1'b1;
            st_next.pend_analog = 1'b0;
         end
         if (st_reg.pend_digital)
         begin
            st_next.trig.digital_started = 1'b1;
            st_next.pend_digital = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         st_reg <= '0;
         st_reg.mode <= fps_pkg::FPS_RESET;
         st_reg.clk <= '{osc_on: 1'b1, osc_fast: 1'b1, cpu_clk_en: 1'b1, afe_clk_en: 1'b1};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata_o = st_reg.rdata;
   assign start_analog_o = st_reg.trig.start_analog;
   assign start_digital_o = st_reg.trig.start_digital;
   assign analog_started_o = st_reg.trig.analog_started;
   assign digital_started_o = st_reg.trig.digital_started;
   assign osc_on_o = st_reg.clk.osc_on;
   assign osc_fast_o = st_reg.clk.osc_fast;
   assign cpu_clk_en_o = st_reg.clk.cpu_clk_en;
   assign afe_clk_en_o = st_reg.clk.afe_clk_en;
endmodule
`default_nettype wire

// file: testbench/fps_frame_phase_sequencer_monitor.sv
`default_nettype none
// Port relations of the sequencer triggers and clock plan
module fps_frame_phase_sequencer_monitor (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic start_analog_o,
   input wire logic start_digital_o,
   input wire logic analog_started_o,
   input wire logic digital_started_o,
   input wire logic osc_on_o,
   input wire logic osc_fast_o,
   input wire logic cpu_clk_en_o,
   input wire logic afe_clk_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   // Confirmations only while the oscillator runs fast
   property p_af; analog_started_o |-> osc_on_o && osc_fast_o; endproperty
   a_af: assert property (p_af) else $error("analog started on slow clock");
   property p_df; digital_started_o |-> osc_on_o && osc_fast_o; endproperty
   a_df: assert property (p_df) else $error("digital started on slow clock");
   property p_ex; !(start_analog_o && start_digital_o); endproperty
   a_ex: assert property (p_ex) else $error("both phase starts at once");
   property p_ap; start_analog_o |=> !start_analog_o; endproperty
   a_ap: assert property (p_ap) else $error("analog start too long");
   property p_dp; start_digital_o |=> !start_digital_o; endproperty
   a_dp: assert property (p_dp) else $error("digital start too long");
   // Oscillator wait is 8 cycles, so 16 leaves margin
   property p_aw; start_analog_o |-> ##[1:16] analog_started_o; endproperty
   a_aw: assert property (p_aw) else $error("analog started missing");
   property p_dw; start_digital_o |-> ##[1:16] digital_started_o; endproperty
   a_dw: assert property (p_dw) else $error("digital started missing");
   property p_sl; !osc_on_o |-> !cpu_clk_en_o && !afe_clk_en_o; endproperty
   a_sl: assert property (p_sl) else $error("clock on in sleep");
   property p_lo; osc_on_o && !osc_fast_o |-> !cpu_clk_en_o; endproperty
   a_lo: assert property (p_lo) else $error("cpu clock on slow oscillator");
   property p_rs; $fell(rst_i) |-> osc_on_o && osc_fast_o && cpu_clk_en_o; endproperty
   a_rs: assert property (p_rs) else $error("slow clock after reset");
   cover property (start_analog_o ##[1:16] analog_started_o);
   cover property (start_digital_o ##1 digital_started_o);
   cover property (!osc_on_o);
endmodule
`default_nettype wire

// file: testbench/fps_afe_model.sv
`default_nettype none
// Analog front end: ends the phase a set time after its start
module fps_afe_model (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [7:0] delay_i,
   output logic done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   logic busy;
   // Done is a level held 9 cycles so the synchroniser sees it
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         busy <= 1'b0;
         cnt <= 8'h00;
         done_o <= 1'b0;
      end
      else if (start_i)
      begin
         busy <= 1'b1;
         cnt <= delay_i;
      end
      else if (busy && cnt == 8'h00)
      begin
         busy <= 1'b0;
         done_o <= 1'b1;
         cnt <= 8'h08;
      end
      else if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
      else
         done_o <= 1'b0;
   end
endmodule
`default_nettype wire

// file: testbench/fps_frame_phase_sequencer_test.sv
`default_nettype none
module fps_frame_phase_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic stop_instr_i = 1'b0;
   logic wake_irq_i = 1'b0;
   logic [7:0] afe_delay = 8'h14; // Conversion time of the model
   logic [7:0] reg_rdata_o;
   logic [7:0] d;
   logic analog_done_i, start_analog_o, start_digital_o, analog_started_o, digital_started_o;
   logic osc_on_o, osc_fast_o, cpu_clk_en_o, afe_clk_en_o;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_ana = 0;
   int n;
   always #5 ref_clk_i = ~ref_clk_i;
   // Count analog starts to prove non-sample frames skip them
   always @(posedge ref_clk_i)
      if (start_analog_o === 1'b1)
         n_ana++;
   fps_frame_phase_sequencer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .stop_instr_i(stop_instr_i),
      .wake_irq_i(wake_irq_i), .analog_done_i(analog_done_i),
      .start_analog_o(start_analog_o), .start_digital_o(start_digital_o),
      .analog_started_o(analog_started_o), .digital_started_o(digital_started_o),
      .osc_on_o(osc_on_o), .osc_fast_o(osc_fast_o), .cpu_clk_en_o(cpu_clk_en_o),
      .afe_clk_en_o(afe_clk_en_o));
   fps_afe_model afe (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(start_analog_o),
      .delay_i(afe_delay), .done_o(analog_done_i));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [15:0] plan();
      return {12'h000, osc_on_o, osc_fast_o, cpu_clk_en_o, afe_clk_en_o};
   endfunction
   function automatic logic pick(input int s);
      case (s)
         0: return start_analog_o;
         1: return start_digital_o;
         2: return analog_started_o;
         default: return digital_started_o;
      endcase
   endfunction
   // Bounded wait for a pulse; n is the cycles it took
   task automatic wait_for(input int s, input int lim, output int n);
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end while (pick(s) !== 1'b1 && n < lim);
      if (pick(s) !== 1'b1)
      begin
         n_mismatch++;
         $display("[ERR] wait %0d expired", s);
         stop_test();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask
   task automatic kick(input logic irq);
      @(posedge ref_clk_i);
      stop_instr_i <= !irq;
      wake_irq_i <= irq;
      @(posedge ref_clk_i);
      stop_instr_i <= 1'b0;
      wake_irq_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic t_reset();
      @(posedge ref_clk_i);
      #1;
      chk("reset plan", plan(), 16'h000f);
      rd(4'h2, d);
      chk("run mode", 16'(d & 8'h07), 16'h0001);
      rd(4'hf, d);
      chk("unmapped", 16'(d), 16'h0000);
   endtask
   task automatic t_nonsample();
      wr(4'h0, 8'h01);
      wait_for(1, 1100, n);
      wait_for(3, 1, n);
      wait_for(1, 1100, n);
      chk("frame gap", 16'(n), 16'h03e7);
      chk("no analog", 16'(n_ana), 16'h0000);
   endtask
   task automatic t_sample();
      wr(4'h1, 8'h09);
      wr(4'h0, 8'h03);
      kick(1'b0);
      chk("idle plan", plan(), 16'h0008);
      rd(4'h2, d);
      chk("idle mode", 16'(d & 8'h07), 16'h0003);
      wait_for(0, 1100, n);
      wait_for(2, 16, n);
      chk("osc wait", 16'(n >= 8), 16'h0001);
      chk("analog plan", plan(), 16'h000d);
      wait_for(1, 64, n);
      chk("end before digital", 16'(analog_done_i), 16'h0001);
      wait_for(3, 16, n);
   endtask
   task automatic t_sleep();
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h04);
      kick(1'b0);
      chk("sleep plan", plan(), 16'h0000);
      kick(1'b1);
      chk("wake plan", plan(), 16'h000f);
   endtask
   task automatic t_debug();
      wr(4'h0, 8'h04);
      wr(4'h1, 8'h01);
      kick(1'b0);
      chk("debug plan", plan(), 16'h000f);
      rd(4'h2, d);
      chk("debug mode", 16'(d & 8'h07), 16'h0002);
      rd(4'h1, d);
      chk("stop readback", 16'(d), 16'h0001);
      kick(1'b1);
   endtask
   initial
   begin
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_nonsample();
      t_sample();
      t_sleep();
      t_debug();
      stop_test();
   end
endmodule
bind fps_frame_phase_sequencer fps_frame_phase_sequencer_monitor mon (.ref_clk_i(ref_clk_i),
   .rst_i(rst_i), .start_analog_o(start_analog_o), .start_digital_o(start_digital_o),
   .analog_started_o(analog_started_o), .digital_started_o(digital_started_o),
   .osc_on_o(osc_on_o), .osc_fast_o(osc_fast_o), .cpu_clk_en_o(cpu_clk_en_o),
   .afe_clk_en_o(afe_clk_en_o));
`default_nettype wire
